/* File: tpr_pkg.sv */
// package for the prohibited-region aware instruction trace core
// assumes one 200 MHz clock shared by core end and trace end
// Functional notes
// - core supplies full per-instruction state; trace tracks
// - address elements carry address and isa
// - context elements carry security, level, width, ids
// - instruction complete after all its elements emitted
// - earlier instruction elements precede later ones
// - core warm reset never resets trace unit
// - block holds one+ instructions, one branch max
// - traced branch is last in block
// - exceptions only at block boundaries
// - block instructions occupy sequential addresses
// - speculative blocks later resolved or canceled
// - resolve means blocks architecturally executed
// - cancel means blocks never executed
// - secure debug disabled makes secure prohibited
// - nothing traced inside prohibited region
// - address comparator never matches when prohibited
// - cycle counter keeps counting while prohibited
// - no element reveals prohibited execution
// - exception into prohibited region still emitted
// - pending speculation resolved after entering region
// - trace-on emitted on exit when view active
// - saved active bit gates exception before first
// - view filter low prohibited/debug, else AND
`default_nettype none
package tpr_pkg;
   localparam int ADDR_W = 64;
   localparam int CTXID_W = 32;
   localparam int TAG_W = 3;
   localparam int CNT_W = 16;
   localparam int FILT_W = 8;
   localparam logic [1:0] EL_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CYC_RESET = 16'h0000;
   localparam logic [3:0] EXC_RESET_TYPE = 4'h0;

   typedef enum logic [3:0] {
      TPR_EL_NONE,
      TPR_EL_TRACE_ON,
      TPR_EL_CONTEXT,
      TPR_EL_TARGET_ADDR,
      TPR_EL_BRANCH,
      TPR_EL_EXCEPTION,
      TPR_EL_CYCLE,
      TPR_EL_COMMIT,
      TPR_EL_CANCEL
   } tpr_elem_t;

   typedef struct packed {
      logic [ADDR_W-1:0]  program_counter;
      logic               thumb_state_bit;
      logic [1:0]         current_exception_level;
      logic               secure;
      logic               width64;
      logic [CTXID_W-1:0] process_context_id;
      logic [CTXID_W-1:0] virtual_context_id;
      logic [FILT_W-1:0]  os_trace_filter_control;
      logic [FILT_W-1:0]  hyp_trace_filter_control;
      logic               secure_trace_enable;
      logic [3:0]         transaction_nesting_depth;
   } tpr_state_t;
endpackage
`default_nettype wire

/* File: tpr_if.sv */
// core-to-trace block channel
// assumes both ends on clk; core end drives, trace end may stall
`timescale 1ns/1ps
`default_nettype none
interface tpr_if;
   import tpr_pkg::*;
   logic             blk_valid;
   logic             blk_ready;
   tpr_state_t       blk_state;
   logic [7:0]       blk_count;
   logic             blk_has_branch;
   logic             blk_taken;
   logic [ADDR_W-1:0] blk_target;
   logic [TAG_W-1:0] blk_tag;
   logic             blk_spec;
   logic             exc_valid;
   logic [3:0]       exc_type;
   logic             res_valid;
   logic [TAG_W-1:0] res_tag;
   logic             can_valid;
   logic [TAG_W-1:0] can_tag;
   logic             prohibited;
   logic             debug_state;
   modport core (output blk_valid, blk_state, blk_count, blk_has_branch, blk_taken, blk_target, blk_tag,
                 blk_spec, exc_valid, exc_type, res_valid, res_tag, can_valid, can_tag, prohibited,
                 debug_state, input blk_ready);
   modport trace (input blk_valid, blk_state, blk_count, blk_has_branch, blk_taken, blk_target, blk_tag,
                  blk_spec, exc_valid, exc_type, res_valid, res_tag, can_valid, can_tag, prohibited,
                  debug_state, output blk_ready);
endinterface
`default_nettype wire

/* File: tpr_core_end.sv */
// core end: turns user block requests into legal blocks
// assumes user holds req until accepted
`timescale 1ns/1ps
`default_nettype none
module tpr_core_end (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // user side
   input  wire logic                 req,
   input  wire tpr_pkg::tpr_state_t  req_state,
   input  wire logic [7:0]           req_count,
   input  wire logic                 req_branch,
   input  wire logic                 req_taken,
   input  wire logic [tpr_pkg::ADDR_W-1:0] req_target,
   input  wire logic [tpr_pkg::TAG_W-1:0]  req_tag,
   input  wire logic                 req_spec,
   input  wire logic                 req_exc,
   input  wire logic [3:0]           req_exc_type,
   input  wire logic                 req_res,
   input  wire logic                 req_can,
   input  wire logic [tpr_pkg::TAG_W-1:0]  req_rc_tag,
   input  wire logic                 secure_noninv_off,
   input  wire logic                 region_prohibited,
   input  wire logic                 in_debug,
   output logic                      req_done,
   // link
   tpr_if.core                       lnk
);
   import tpr_pkg::*;
   // =========================================
   // block issue
   logic busy_r, busy_nxt;
   always_comb begin
      busy_nxt = busy_r;
      if (busy_r && lnk.blk_ready) begin
         busy_nxt = 1'b0;
      end else if (!busy_r && req && !req_done) begin
         busy_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
      end
   end
   assign req_done = busy_r && lnk.blk_ready;
   assign lnk.blk_valid = busy_r;
   assign lnk.blk_state = req_state;
   assign lnk.blk_count = (req_count == 8'h00) ? 8'h01 : req_count;
   assign lnk.blk_has_branch = req_branch;
   assign lnk.blk_taken = req_taken & req_branch;
   assign lnk.blk_target = req_target;
   assign lnk.blk_tag = req_tag;
   assign lnk.blk_spec = req_spec;
   // events last one cycle, ahead of the block; raise only with core end idle
   assign lnk.exc_valid = req && req_exc && !busy_r;
   assign lnk.exc_type = req_exc_type;
   assign lnk.res_valid = req && req_res && !busy_r;
   assign lnk.can_valid = req && req_can && !req_res && !busy_r;
   assign lnk.res_tag = req_rc_tag;
   assign lnk.can_tag = req_rc_tag;
   assign lnk.prohibited = region_prohibited | (secure_noninv_off & req_state.secure);
   assign lnk.debug_state = in_debug;
endmodule
`default_nettype wire

/* File: tpr_trace_end.sv */
// trace end: emits ordered trace elements from core blocks
// assumes filter terms come from elsewhere; one element per cycle
`timescale 1ns/1ps
`default_nettype none
module tpr_trace_end #(
   parameter int TAGS = 8
) (
   // clock and trace unit reset, independent of core warm reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // filter and resource inputs
   input  wire logic                 start_stop_ok,
   input  wire logic                 incl_excl_ok,
   input  wire logic                 el_filter_ok,
   input  wire logic                 event_ok,
   input  wire logic                 cyc_count_en,
   input  wire logic [tpr_pkg::ADDR_W-1:0] cmp_addr,
   input  wire logic                 saved_trace_active_bit,
   output logic                      addr_match,
   output logic                      instruction_view_filter,
   // element output
   output logic                      el_valid,
   input  wire logic                 el_ready,
   output tpr_pkg::tpr_elem_t        el_kind,
   output logic [tpr_pkg::ADDR_W-1:0] el_addr,
   output logic                      el_isa,
   output logic [tpr_pkg::CTXID_W-1:0] el_ctx_proc,
   output logic [tpr_pkg::CTXID_W-1:0] el_ctx_virt,
   output logic [1:0]                el_ctx_el,
   output logic                      el_ctx_secure,
   output logic                      el_ctx_width64,
   output logic [tpr_pkg::CNT_W-1:0] el_count,
   output logic                      instr_done,
   // link
   tpr_if.trace                      lnk
);
   import tpr_pkg::*;
   typedef enum logic [2:0] {TPR_IDLE, TPR_ON, TPR_CTX, TPR_ADDR, TPR_BR, TPR_CYC} tpr_st_t;

   // =========================================
   // view filter and comparator
   logic filt_ok;
   assign filt_ok = !lnk.debug_state && start_stop_ok && incl_excl_ok && el_filter_ok && event_ok;
   assign instruction_view_filter = !lnk.prohibited && filt_ok;
   assign addr_match = !lnk.prohibited && lnk.blk_valid &&
                       (lnk.blk_state.program_counter == cmp_addr);

   // =========================================
   // state
   tpr_st_t st_r, st_nxt;
   logic was_prohib_r, was_prohib_nxt;
   logic first_pending_r, first_pending_nxt;
   logic [CNT_W-1:0] cyc_r, cyc_nxt;
   logic [CNT_W-1:0] x_r, x_nxt, gamma_r, gamma_nxt;
   logic [CNT_W-1:0] map_r [TAGS], map_nxt [TAGS];
   tpr_state_t hold_r, hold_nxt;
   logic hold_br_r, hold_br_nxt, hold_tk_r, hold_tk_nxt;
   logic [ADDR_W-1:0] hold_tgt_r, hold_tgt_nxt;
   tpr_elem_t kind_r, kind_nxt;
   logic vld_r, vld_nxt, done_r, done_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic isa_r, isa_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   logic out_free;
   logic view_blk;
   assign out_free = !vld_r || el_ready;
   assign view_blk = instruction_view_filter;

   always_comb begin
      st_nxt = st_r;
      was_prohib_nxt = was_prohib_r;
      first_pending_nxt = first_pending_r;
      cyc_nxt = cyc_en_inc(cyc_r);
      x_nxt = x_r;
      gamma_nxt = gamma_r;
      map_nxt = map_r;
      hold_nxt = hold_r;
      hold_br_nxt = hold_br_r;
      hold_tk_nxt = hold_tk_r;
      hold_tgt_nxt = hold_tgt_r;
      vld_nxt = vld_r && !el_ready;
      kind_nxt = kind_r;
      addr_nxt = addr_r;
      isa_nxt = isa_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      lnk.blk_ready = 1'b0;
      if (lnk.prohibited) begin
         was_prohib_nxt = 1'b1;
      end
      if (out_free) begin
         case (st_r)
            TPR_IDLE: begin
               if (lnk.res_valid) begin
                  // commit count survives prohibited region
                  vld_nxt = 1'b1;
                  kind_nxt = TPR_EL_COMMIT;
                  cnt_nxt = map_r[lnk.res_tag] - gamma_r;
                  gamma_nxt = map_r[lnk.res_tag];
               end else if (lnk.can_valid) begin
                  vld_nxt = 1'b1;
                  kind_nxt = TPR_EL_CANCEL;
                  cnt_nxt = x_r - map_r[lnk.can_tag];
                  x_nxt = map_r[lnk.can_tag];
               end else if (lnk.exc_valid) begin
                  // traced if view active, or pending-first gated by saved bit
                  // entry exception judged by filter terms alone
                  if ((!lnk.prohibited && (first_pending_r ? saved_trace_active_bit : view_blk)) ||
                      (lnk.prohibited && !was_prohib_r && filt_ok)) begin
                     vld_nxt = 1'b1;
                     kind_nxt = TPR_EL_EXCEPTION;
                     cnt_nxt = {{(CNT_W-4){1'b0}}, lnk.exc_type};
                     addr_nxt = lnk.prohibited ? '0 : hold_r.program_counter;
                     isa_nxt = lnk.prohibited ? 1'b0 : hold_r.thumb_state_bit;
                  end
               end else if (lnk.blk_valid) begin
                  lnk.blk_ready = 1'b1;
                  first_pending_nxt = 1'b0;
                  if (lnk.prohibited) begin
                     // dropped silently
                     done_nxt = 1'b0;
                  end else begin
                     hold_nxt = lnk.blk_state;
                     hold_br_nxt = lnk.blk_has_branch;
                     hold_tk_nxt = lnk.blk_taken;
                     hold_tgt_nxt = lnk.blk_target;
                     if (lnk.blk_has_branch) begin
                        x_nxt = x_r + 16'h0001;
                        map_nxt[lnk.blk_tag] = x_r + 16'h0001;
                        if (!lnk.blk_spec) begin
                           gamma_nxt = x_r + 16'h0001;
                        end
                     end
                     if (view_blk) begin
                        st_nxt = was_prohib_r ? TPR_ON : TPR_BR;
                     end else begin
                        done_nxt = 1'b1;
                     end
                     was_prohib_nxt = 1'b0;
                  end
               end else if (!lnk.prohibited && was_prohib_r) begin
                  first_pending_nxt = 1'b1;
               end
            end
            TPR_ON: begin
               vld_nxt = 1'b1;
               kind_nxt = TPR_EL_TRACE_ON;
               st_nxt = TPR_CTX;
            end
            TPR_CTX: begin
               vld_nxt = 1'b1;
               kind_nxt = TPR_EL_CONTEXT;
               st_nxt = TPR_ADDR;
            end
            TPR_ADDR: begin
               vld_nxt = 1'b1;
               kind_nxt = TPR_EL_TARGET_ADDR;
               addr_nxt = hold_r.program_counter;
               isa_nxt = hold_r.thumb_state_bit;
               st_nxt = TPR_BR;
            end
            TPR_BR: begin
               st_nxt = TPR_CYC;
               if (hold_br_r) begin
                  vld_nxt = 1'b1;
                  kind_nxt = TPR_EL_BRANCH;
                  addr_nxt = hold_tk_r ? hold_tgt_r : hold_r.program_counter;
                  isa_nxt = hold_r.thumb_state_bit;
                  cnt_nxt = {{(CNT_W-1){1'b0}}, hold_tk_r};
               end
            end
            TPR_CYC: begin
               // elements for one block leave before the next is taken
               st_nxt = TPR_IDLE;
               done_nxt = 1'b1;
               if (cyc_count_en && hold_br_r) begin
                  vld_nxt = 1'b1;
                  kind_nxt = TPR_EL_CYCLE;
                  cnt_nxt = cyc_r;
                  cyc_nxt = CYC_RESET;
               end
            end
            default: st_nxt = TPR_IDLE;
         endcase
      end
   end

   function automatic logic [CNT_W-1:0] cyc_en_inc(input logic [CNT_W-1:0] c);
      cyc_en_inc = cyc_count_en ? c + 16'h0001 : c;
   endfunction

   // rstn is the trace unit reset only; core warm reset not wired here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= TPR_IDLE;
         was_prohib_r <= 1'b0;
         first_pending_r <= 1'b0;
         cyc_r <= CYC_RESET;
         x_r <= '0;
         gamma_r <= '0;
         for (int i = 0; i < TAGS; i++) begin
            map_r[i] <= '0;
         end
         hold_r <= '0;
         hold_br_r <= 1'b0;
         hold_tk_r <= 1'b0;
         hold_tgt_r <= '0;
         vld_r <= 1'b0;
         kind_r <= TPR_EL_NONE;
         addr_r <= '0;
         isa_r <= 1'b0;
         cnt_r <= '0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         was_prohib_r <= was_prohib_nxt;
         first_pending_r <= first_pending_nxt;
         cyc_r <= cyc_nxt;
         x_r <= x_nxt;
         gamma_r <= gamma_nxt;
         map_r <= map_nxt;
         hold_r <= hold_nxt;
         hold_br_r <= hold_br_nxt;
         hold_tk_r <= hold_tk_nxt;
         hold_tgt_r <= hold_tgt_nxt;
         vld_r <= vld_nxt;
         kind_r <= kind_nxt;
         addr_r <= addr_nxt;
         isa_r <= isa_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign el_valid = vld_r;
   assign el_kind = kind_r;
   assign el_addr = addr_r;
   assign el_isa = isa_r;
   assign el_count = cnt_r;
   assign instr_done = done_r;
   assign el_ctx_proc = hold_r.process_context_id;
   assign el_ctx_virt = hold_r.virtual_context_id;
   assign el_ctx_el = hold_r.current_exception_level;
   assign el_ctx_secure = hold_r.secure;
   assign el_ctx_width64 = hold_r.width64;
endmodule
`default_nettype wire

/* File: tpr_properties.sv */
// checker of the core-to-trace block channel
// assumes instantiation beside tpr_if, clocked by clk
`timescale 1ns/1ps
`default_nettype none
module tpr_properties (
   // clock and reset
   input wire logic                      clk,
   input wire logic                      rstn,
   // channel
   input wire logic                      blk_valid,
   input wire logic                      blk_ready,
   input wire tpr_pkg::tpr_state_t       blk_state,
   input wire logic [7:0]                blk_count,
   input wire logic                      blk_has_branch,
   input wire logic [tpr_pkg::TAG_W-1:0] blk_tag,
   input wire logic                      exc_valid,
   input wire logic                      res_valid,
   input wire logic                      can_valid,
   input wire logic                      prohibited,
   input wire logic                      debug_state
);
   import tpr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========
   // offer and take
   sequence s_wait;
      blk_valid && !blk_ready;
   endsequence
   sequence s_take;
      blk_valid && blk_ready && blk_has_branch && !prohibited && !debug_state;
   endsequence
   a_offer_held: assert property (s_wait |=> blk_valid && $stable(blk_state))
      else $error("block offer changed before take");
   a_branch_held: assert property (s_wait |=> $stable(blk_has_branch) && $stable(blk_tag))
      else $error("branch or tag changed before take");
   a_count_held: assert property (s_wait |=> $stable(blk_count))
      else $error("block count changed before take");
   a_block_nonempty: assert property (blk_valid |-> blk_count != 8'h00)
      else $error("empty block offered");
   a_exc_boundary: assert property (exc_valid |-> !blk_valid && !blk_ready)
      else $error("exception inside a block");
   a_res_first: assert property (res_valid |-> !blk_ready)
      else $error("block taken over resolve");
   a_can_first: assert property (can_valid |-> !blk_ready)
      else $error("block taken over cancel");
   a_busy_after_take: assert property (s_take |=> !blk_ready)
      else $error("next block taken before elements");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench joining core end and trace end over tpr_if
// assumes 200 MHz clk, active low async rstn
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tpr_pkg::*;
   // ==========
   // signals
   logic clk, rstn, req, req_branch, req_taken, req_spec, req_exc, req_res, req_can, req_done;
   logic secure_noninv_off, region_prohibited, in_debug, stall;
   logic start_stop_ok, incl_excl_ok, el_filter_ok, event_ok, cyc_count_en, saved_trace_active_bit;
   logic addr_match, instruction_view_filter, el_valid, el_ready, el_isa, el_ctx_secure, el_ctx_width64;
   logic instr_done, am_seen;
   tpr_state_t req_state;
   logic [7:0] req_count;
   logic [ADDR_W-1:0] req_target, cmp_addr, el_addr;
   logic [TAG_W-1:0] req_tag, req_rc_tag;
   logic [3:0] req_exc_type;
   tpr_elem_t el_kind;
   logic [CTXID_W-1:0] el_ctx_proc, el_ctx_virt;
   logic [1:0] el_ctx_el;
   logic [CNT_W-1:0] el_count;
   int miscompares, check_count, done_n;
   tpr_elem_t q_kind[$];
   logic [CNT_W-1:0] q_cnt[$];
   logic [ADDR_W-1:0] q_addr[$];
   // ==========
   // ends and checker
   tpr_if lnk ();
   tpr_core_end i_tpr_core_end (.clk, .rstn, .req, .req_state, .req_count, .req_branch, .req_taken,
      .req_target, .req_tag, .req_spec, .req_exc, .req_exc_type, .req_res, .req_can, .req_rc_tag,
      .secure_noninv_off, .region_prohibited, .in_debug, .req_done, .lnk(lnk.core));
   tpr_trace_end #(.TAGS(8)) i_tpr_trace_end (.clk, .rstn, .start_stop_ok, .incl_excl_ok, .el_filter_ok,
      .event_ok, .cyc_count_en, .cmp_addr, .saved_trace_active_bit, .addr_match, .instruction_view_filter,
      .el_valid, .el_ready, .el_kind, .el_addr, .el_isa, .el_ctx_proc, .el_ctx_virt, .el_ctx_el,
      .el_ctx_secure, .el_ctx_width64, .el_count, .instr_done, .lnk(lnk.trace));
   tpr_properties u_props (.clk, .rstn, .blk_valid(lnk.blk_valid), .blk_ready(lnk.blk_ready),
      .blk_state(lnk.blk_state), .blk_count(lnk.blk_count), .blk_has_branch(lnk.blk_has_branch),
      .blk_tag(lnk.blk_tag), .exc_valid(lnk.exc_valid), .res_valid(lnk.res_valid),
      .can_valid(lnk.can_valid), .prohibited(lnk.prohibited), .debug_state(lnk.debug_state));
   // ==========
   // clock, element monitor, watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (el_valid && el_ready) begin
         q_kind.push_back(el_kind);
         q_cnt.push_back(el_count);
         q_addr.push_back(el_addr);
      end
      if (instr_done) done_n++;
      el_ready <= stall ? ~el_ready : 1'b1;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end
   // ==========
   // helpers
   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic int n_of(tpr_elem_t k);
      n_of = 0;
      foreach (q_kind[i]) if (q_kind[i] === k) n_of++;
   endfunction
   task automatic clr();
      @(negedge clk);
      q_kind.delete();
      q_cnt.delete();
      q_addr.delete();
      done_n = 0;
      am_seen = 1'b0;
   endtask
   task automatic kinds(tpr_elem_t e[$]);
      chk("elements", e.size(), q_kind.size());
      foreach (e[i]) chk("kind", e[i], q_kind[i]);
   endtask
   task automatic send(logic b, s, x, r, c, logic [TAG_W-1:0] t, logic p = 1'b0);
      int n;
      // let the trace end drain so a one-cycle event is seen in idle
      repeat (6) @(posedge clk);
      req <= 1'b1;
      req_branch <= b;
      req_spec <= s;
      req_exc <= x;
      req_res <= r;
      req_can <= c;
      req_tag <= t;
      req_rc_tag <= t;
      if (p) region_prohibited <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         am_seen = am_seen | addr_match;
         n++;
      end while (!req_done && n < 100);
      chk("req_done", 1, req_done);
      @(posedge clk);
      req <= 1'b0;
   endtask
   task automatic bounce(logic sa);
      @(posedge clk) region_prohibited <= 1'b1;
      repeat (5) @(posedge clk);
      region_prohibited <= 1'b0;
      saved_trace_active_bit <= sa;
      clr();
      send(0, 0, 1, 0, 0, 0);
      repeat (20) @(posedge clk);
      chk("exc_after_exit", {63'h0, sa}, n_of(TPR_EL_EXCEPTION));
   endtask
   // ==========
   // scenarios
   task automatic t_plain();
      clr();
      send(1, 0, 0, 0, 0, 0);
      send(0, 0, 0, 0, 0, 0);
      send(1, 0, 0, 0, 0, 0);
      repeat (20) @(posedge clk);
      kinds('{TPR_EL_BRANCH, TPR_EL_BRANCH});
      chk("done", 3, done_n);
      $display("t_plain end");
   endtask
   task automatic t_spec();
      clr();
      send(1, 1, 0, 0, 0, 1);
      send(0, 0, 0, 1, 0, 1);
      send(1, 1, 0, 0, 0, 2);
      send(1, 1, 0, 0, 0, 3);
      send(0, 0, 0, 0, 1, 2, 1);
      repeat (20) @(posedge clk);
      kinds('{TPR_EL_BRANCH, TPR_EL_COMMIT, TPR_EL_BRANCH, TPR_EL_BRANCH, TPR_EL_CANCEL});
      chk("commit_n", 1, q_cnt[1]);
      chk("cancel_n", 1, q_cnt[4]);
      $display("t_spec end");
   endtask
   task automatic t_prohib();
      @(posedge clk) cyc_count_en <= 1'b1;
      cmp_addr <= req_state.program_counter;
      clr();
      send(1, 0, 0, 0, 0, 4);
      send(0, 0, 1, 0, 0, 0);
      repeat (40) @(posedge clk);
      chk("prohib_elems", 0, q_kind.size());
      chk("prohib_done", 0, done_n);
      chk("addr_match", 0, am_seen);
      $display("t_prohib end");
   endtask
   task automatic t_exit();
      @(posedge clk) region_prohibited <= 1'b0;
      stall <= 1'b1;
      clr();
      send(1, 0, 0, 0, 0, 5);
      repeat (40) @(posedge clk);
      kinds('{TPR_EL_TRACE_ON, TPR_EL_CONTEXT, TPR_EL_TARGET_ADDR, TPR_EL_BRANCH, TPR_EL_CYCLE});
      chk("target", req_state.program_counter, q_addr[2]);
      chk("addr_match_on", 1, am_seen);
      chk("cycles", 1, q_cnt[4] >= 16'd40);
      chk("ctx", {req_state.process_context_id, req_state.virtual_context_id}, {el_ctx_proc, el_ctx_virt});
      chk("ctx_mode", {2'h1, 1'b0, 1'b1}, {el_ctx_el, el_ctx_secure, el_ctx_width64});
      stall <= 1'b0;
      $display("t_exit end");
   endtask
   task automatic t_edges();
      bounce(1'b0);
      bounce(1'b1);
      clr();
      req_exc_type <= 4'h5;
      send(0, 0, 1, 0, 0, 0, 1);
      repeat (20) @(posedge clk);
      chk("exc_entry", 1, n_of(TPR_EL_EXCEPTION));
      $display("t_edges end");
   endtask
   task automatic t_view();
      for (int v = 0; v < 256; v++) begin
         @(posedge clk);
         {req_state.secure, secure_noninv_off, region_prohibited, in_debug,
          start_stop_ok, incl_excl_ok, el_filter_ok, event_ok} <= v[7:0];
         @(negedge clk);
         chk("view", (&v[3:0]) && !v[4] && !v[5] && !(v[6] && v[7]), instruction_view_filter);
      end
      $display("t_view end");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      {rstn, req, req_branch, req_taken, req_spec, req_exc, req_res, req_can} = 8'h10;
      {secure_noninv_off, region_prohibited, in_debug, stall, cyc_count_en} = 5'h00;
      {start_stop_ok, incl_excl_ok, el_filter_ok, event_ok, saved_trace_active_bit} = 5'h1f;
      {el_ready, miscompares, check_count, done_n} = '0;
      req_state = '0;
      req_state.program_counter = 64'h0000_0000_0000_1000;
      req_state.thumb_state_bit = 1'b1;
      req_state.current_exception_level = 2'h1;
      req_state.width64 = 1'b1;
      req_state.process_context_id = 32'h0000_0011;
      req_state.virtual_context_id = 32'h0000_0022;
      req_state.secure_trace_enable = 1'b1;
      {req_count, req_target, cmp_addr} = {8'h04, 64'h0000_0000_0000_2000, 64'h0};
      {req_tag, req_rc_tag, req_exc_type} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_plain();
      t_spec();
      t_prohib();
      t_exit();
      t_edges();
      t_view();
      tally_and_finish();
   end
endmodule
`default_nettype wire
